// ### inc/zcl_pkg.sv
// =====================================================================
// zcl_pkg: shared constants and carriers of the zero-cross logic block
// =====================================================================
// assumes an 8-bit register port with a 3-bit word offset and a
// single 100 MHz system clock.
package zcl_pkg;

    // =================================================================
    // widths
    // =================================================================
    localparam int ZCL_AW = 3;                      // register offset width
    localparam int ZCL_DW = 8;                      // register data width

    // =================================================================
    // register offsets
    // =================================================================
    localparam logic [2:0] ZCL_OFF_CONTROL  = 3'h0; // crossing_control_reg
    localparam logic [2:0] ZCL_OFF_FLAGS    = 3'h1; // peripheral_flag_reg_two
    localparam logic [2:0] ZCL_OFF_ENABLES  = 3'h2; // peripheral_enable_reg_two
    localparam logic [2:0] ZCL_OFF_IRQCTL   = 3'h3; // irq_control_reg
    localparam logic [2:0] ZCL_OFF_MODDIS   = 3'h4; // module_disable_reg_three

    // =================================================================
    // field positions
    // =================================================================
    localparam int ZCL_BIT_SOFT_EN  = 7;            // control: soft_enable
    localparam int ZCL_BIT_OUT      = 5;            // control: read-only output
    localparam int ZCL_BIT_INVERT   = 4;            // control: output_invert
    localparam int ZCL_BIT_RISE_EN  = 1;            // control: rise_irq_enable
    localparam int ZCL_BIT_FALL_EN  = 0;            // control: fall_irq_enable
    localparam int ZCL_BIT_FLAG     = 0;            // flags: crossing_irq_flag
    localparam int ZCL_BIT_IRQ_EN   = 0;            // enables: crossing_irq_enable
    localparam int ZCL_BIT_GLOBAL   = 7;            // irqctl: global_irq_gate
    localparam int ZCL_BIT_PERIPH   = 6;            // irqctl: peripheral_irq_gate
    localparam int ZCL_BIT_MODDIS   = 0;            // moddis: crossing_module_disable

    // =================================================================
    // reset values
    // =================================================================
    localparam logic       ZCL_RST_BIT   = 1'b0;    // every control bit clears
    localparam logic       ZCL_RST_FUSE  = 1'b1;    // disabled until fuse is caught
    localparam logic [7:0] ZCL_RST_DATA  = 8'h00;   // read data at rest

    // =================================================================
    // carriers
    // =================================================================
    // one register request from the processor side
    typedef struct packed {
        logic [2:0] addr;                           // word offset
        logic [7:0] wdata;                          // write data
        logic       wr;                             // write strobe
        logic       rd;                             // read strobe
    } zcl_bus_req_t;

    // polarity-adjusted output as offered to the timers
    typedef struct packed {
        logic gate_odd;                             // gate source, odd timers
        logic clk_even;                             // clock source, even timers
        logic rst_even;                             // reset source, even timers
    } zcl_timer_src_t;

endpackage

// ### rtl/zcl_sync.sv
// =====================================================================
// zcl_sync: three-stage synchroniser with agreement filter
// =====================================================================
// assumes din is asynchronous to clock; q changes only once the second
// and third stages agree, so one metastable sample never leaks out.
`timescale 1ns/10ps

module zcl_sync (
    input  wire logic clock,                        // system clock
    input  wire logic resetn,                       // async reset, active low
    input  wire logic din,                          // asynchronous level
    output logic      q                             // filtered level
);
    import zcl_pkg::*;

    logic s1_ff;                                    // first stage, read by s2 only
    logic s2_ff;                                    // second stage
    logic s3_ff;                                    // third stage
    logic q_ff;                                     // accepted level

    // =================================================================
    // shift chain
    // =================================================================
    // the first stage feeds nothing but the second stage
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= ZCL_RST_BIT;
            s2_ff <= ZCL_RST_BIT;
            s3_ff <= ZCL_RST_BIT;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // =================================================================
    // agreement filter
    // =================================================================
    // accept a new level only when two settled stages match
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q_ff <= ZCL_RST_BIT;
        end else if (s2_ff == s3_ff) begin
            q_ff <= s3_ff;
        end
    end

    assign q = q_ff;

endmodule

// ### rtl/zcl_top.sv
// =====================================================================
// zcl_top: digital side of the zero-cross detector
// =====================================================================
// assumes the analog front end drives sink_active high while the pin
// sinks current, a register master on the same clock, and a fuse level
// that is stable from power-on. nothing here stops in sleep.
`timescale 1ns/10ps

// Notes on behaviour
// - raw state high on sink, low on source
// - front end choice of sink/source is input
// - invert set flips output; clear follows raw
// - output offered as timer gate/clock/reset
// - separate rising and falling edge detectors
// - enabled edge sets the shared crossing flag
// - request needs flag and three enables set
// - invert write makes edge, regardless of enable
// - software clears flag; set beats clear
// - all detection keeps running during sleep
// - fuse clear: active unless module disabled, soft enable ignored
// - fuse set: disabled until soft enable
// - module disable switches off, either fuse state
// - fuse set plus soft enable forces pin drive
module zcl_top (
    input  wire logic             clock,            // system clock, 100 MHz
    input  wire logic             resetn,           // async reset, active low
    input  wire zcl_pkg::zcl_bus_req_t bus_req,     // register request
    output logic [7:0]            rdata,            // read data, cycle after read
    input  wire logic             sink_active,      // front end: pin sinking current
    input  wire logic             config_fuse,      // crossing_config_fuse level
    output zcl_pkg::zcl_timer_src_t timer_src,      // output to timer modules
    output logic                  force_pin_drive,  // pin driven by current loop
    output logic                  irq               // interrupt to the processor
);
    import zcl_pkg::*;

    // =================================================================
    // declarations
    // =================================================================
    logic       raw_sync;                           // synchronised raw state
    logic       fuse_ff;                            // captured fuse level
    logic       fuse_done_ff;                       // fuse already captured
    logic       soft_enable_ff;                     // software enable
    logic       output_invert_ff;                   // polarity select
    logic       rise_en_ff;                         // rising edge enable
    logic       fall_en_ff;                         // falling edge enable
    logic       flag_ff;                            // crossing_irq_flag
    logic       irq_en_ff;                          // crossing_irq_enable
    logic       global_gate_ff;                     // global_irq_gate
    logic       periph_gate_ff;                     // peripheral_irq_gate
    logic       mod_dis_ff;                         // crossing_module_disable
    logic       active_ff;                          // detector running
    logic       out_ff;                             // polarity-adjusted output
    logic       prev_ff;                            // output one cycle earlier
    logic       irq_ff;                             // registered request
    logic [7:0] rdata_ff;                           // registered read data
    logic       nxt_active;                         // next running state
    logic       nxt_out;                            // next adjusted output
    logic       rise_edge;                          // rising edge seen
    logic       fall_edge;                          // falling edge seen
    logic       set_flag;                           // enabled edge seen
    logic       clr_flag;                           // write of one to flag
    logic       wr_control;                         // control register write
    logic [7:0] nxt_rdata;                          // read mux result

    // =================================================================
    // helper functions
    // =================================================================
    // address match for one strobe, used by writes and reads
    function automatic logic hit(input logic strobe, input logic [2:0] a,
                                 input logic [2:0] off);
        hit = strobe && (a == off);
    endfunction

    // polarity: invert flips the raw state, zero passes it
    function automatic logic polarize(input logic raw, input logic inv);
        polarize = raw ^ inv;
    endfunction

    // =================================================================
    // input synchroniser
    // =================================================================
    // the front end's choice is asynchronous to clock
    zcl_sync u_sync (
        .clock  (clock),
        .resetn (resetn),
        .din    (sink_active),
        .q      (raw_sync)
    );

    // =================================================================
    // fuse capture
    // =================================================================
    // the fuse is caught once after reset release; until then the
    // block behaves as if the fuse were set, i.e. stays disabled
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fuse_ff      <= ZCL_RST_FUSE;
            fuse_done_ff <= ZCL_RST_BIT;
        end else if (!fuse_done_ff) begin
            fuse_ff      <= config_fuse;
            fuse_done_ff <= 1'b1;
        end
    end

    // =================================================================
    // register write decode
    // =================================================================
    assign wr_control = hit(bus_req.wr, bus_req.addr, ZCL_OFF_CONTROL);
    assign clr_flag   = hit(bus_req.wr, bus_req.addr, ZCL_OFF_FLAGS) &&
                        bus_req.wdata[ZCL_BIT_FLAG];

    // control register fields
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            soft_enable_ff   <= ZCL_RST_BIT;
            output_invert_ff <= ZCL_RST_BIT;
            rise_en_ff       <= ZCL_RST_BIT;
            fall_en_ff       <= ZCL_RST_BIT;
        end else if (wr_control) begin
            soft_enable_ff   <= bus_req.wdata[ZCL_BIT_SOFT_EN];
            output_invert_ff <= bus_req.wdata[ZCL_BIT_INVERT];
            rise_en_ff       <= bus_req.wdata[ZCL_BIT_RISE_EN];
            fall_en_ff       <= bus_req.wdata[ZCL_BIT_FALL_EN];
        end
    end

    // interrupt enable register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_en_ff <= ZCL_RST_BIT;
        end else if (hit(bus_req.wr, bus_req.addr, ZCL_OFF_ENABLES)) begin
            irq_en_ff <= bus_req.wdata[ZCL_BIT_IRQ_EN];
        end
    end

    // global and peripheral gates
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            global_gate_ff <= ZCL_RST_BIT;
            periph_gate_ff <= ZCL_RST_BIT;
        end else if (hit(bus_req.wr, bus_req.addr, ZCL_OFF_IRQCTL)) begin
            global_gate_ff <= bus_req.wdata[ZCL_BIT_GLOBAL];
            periph_gate_ff <= bus_req.wdata[ZCL_BIT_PERIPH];
        end
    end

    // module disable register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mod_dis_ff <= ZCL_RST_BIT;
        end else if (hit(bus_req.wr, bus_req.addr, ZCL_OFF_MODDIS)) begin
            mod_dis_ff <= bus_req.wdata[ZCL_BIT_MODDIS];
        end
    end

    // =================================================================
    // enable resolution
    // =================================================================
    // fuse clear: soft enable ignored, only module disable stops it;
    // fuse set: soft enable starts it, module disable overrides
    always_comb begin
        if (fuse_ff) begin
            nxt_active = soft_enable_ff && !mod_dis_ff;
        end else begin
            nxt_active = !mod_dis_ff;
        end
    end

    // running state; also drives the pin into current-loop mode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            active_ff <= ZCL_RST_BIT;
        end else begin
            active_ff <= nxt_active;
        end
    end

    // =================================================================
    // logic output and edge detectors
    // =================================================================
    // a stopped detector reads raw low; invert still applies, so a
    // write to invert moves the output even with the detector off
    assign nxt_out = polarize(active_ff && raw_sync,
                              output_invert_ff);

    // output and its one-cycle history, never gated by sleep
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out_ff  <= ZCL_RST_BIT;
            prev_ff <= ZCL_RST_BIT;
        end else begin
            out_ff  <= nxt_out;
            prev_ff <= out_ff;
        end
    end

    assign rise_edge = out_ff && !prev_ff;
    assign fall_edge = !out_ff && prev_ff;
    assign set_flag  = (rise_edge && rise_en_ff) ||
                       (fall_edge && fall_en_ff);

    // =================================================================
    // crossing flag and request
    // =================================================================
    // sticky; an edge in the clearing cycle keeps the flag set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flag_ff <= ZCL_RST_BIT;
        end else if (set_flag) begin
            flag_ff <= 1'b1;
        end else if (clr_flag) begin
            flag_ff <= 1'b0;
        end
    end

    // level request, held while the flag and all gates are set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_ff <= ZCL_RST_BIT;
        end else begin
            irq_ff <= flag_ff && irq_en_ff &&
                      periph_gate_ff && global_gate_ff;
        end
    end

    // =================================================================
    // read path
    // =================================================================
    // unmapped offsets and idle cycles read zero
    always_comb begin
        nxt_rdata = ZCL_RST_DATA;
        if (hit(bus_req.rd, bus_req.addr, ZCL_OFF_CONTROL)) begin
            nxt_rdata[ZCL_BIT_SOFT_EN] = soft_enable_ff;
            nxt_rdata[ZCL_BIT_OUT]     = out_ff;
            nxt_rdata[ZCL_BIT_INVERT]  = output_invert_ff;
            nxt_rdata[ZCL_BIT_RISE_EN] = rise_en_ff;
            nxt_rdata[ZCL_BIT_FALL_EN] = fall_en_ff;
        end else if (hit(bus_req.rd, bus_req.addr, ZCL_OFF_FLAGS)) begin
            nxt_rdata[ZCL_BIT_FLAG]    = flag_ff;
        end else if (hit(bus_req.rd, bus_req.addr, ZCL_OFF_ENABLES)) begin
            nxt_rdata[ZCL_BIT_IRQ_EN]  = irq_en_ff;
        end else if (hit(bus_req.rd, bus_req.addr, ZCL_OFF_IRQCTL)) begin
            nxt_rdata[ZCL_BIT_GLOBAL]  = global_gate_ff;
            nxt_rdata[ZCL_BIT_PERIPH]  = periph_gate_ff;
        end else if (hit(bus_req.rd, bus_req.addr, ZCL_OFF_MODDIS)) begin
            nxt_rdata[ZCL_BIT_MODDIS]  = mod_dis_ff;
        end
    end

    // data stand in the cycle after the strobe only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= ZCL_RST_DATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // =================================================================
    // outputs, each straight from a flip-flop
    // =================================================================
    assign rdata              = rdata_ff;
    assign timer_src.gate_odd = out_ff;
    assign timer_src.clk_even = out_ff;
    assign timer_src.rst_even = out_ff;
    assign force_pin_drive    = active_ff;
    assign irq                = irq_ff;

    // =================================================================
    // assertions
    // =================================================================
    property p_out_raw;
        @(posedge clock) disable iff (!resetn)
        (active_ff && !output_invert_ff) |=> (out_ff == $past(raw_sync));
    endproperty
    a_out_raw: assert property (p_out_raw)
        else $error("output does not follow raw state");

    property p_out_inv;
        @(posedge clock) disable iff (!resetn)
        (active_ff && output_invert_ff) |=> (out_ff == !$past(raw_sync));
    endproperty
    a_out_inv: assert property (p_out_inv)
        else $error("inverted output wrong");

    property p_rise_sets;
        @(posedge clock) disable iff (!resetn)
        (rise_en_ff && out_ff && !prev_ff) |=> flag_ff;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("enabled rising edge did not set flag");

    property p_fall_sets;
        @(posedge clock) disable iff (!resetn)
        (fall_en_ff && !out_ff && prev_ff) |=> flag_ff;
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("enabled falling edge did not set flag");

    property p_no_spurious;
        @(posedge clock) disable iff (!resetn)
        (!flag_ff && !set_flag) |=> !flag_ff;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("flag set without enabled edge");

    property p_set_wins;
        @(posedge clock) disable iff (!resetn)
        (set_flag && clr_flag) |=> flag_ff;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a simultaneous set");

    property p_irq;
        @(posedge clock) disable iff (!resetn)
        1'b1 |=> (irq == $past(flag_ff && irq_en_ff && periph_gate_ff &&
                               global_gate_ff));
    endproperty
    a_irq: assert property (p_irq)
        else $error("request does not match flag and gates");

    property p_invert_edge;
        @(posedge clock) disable iff (!resetn)
        (wr_control && (bus_req.wdata[ZCL_BIT_INVERT] != output_invert_ff))
        ##1 ($stable(raw_sync) && $stable(active_ff))
        |=> (out_ff != prev_ff);
    endproperty
    a_invert_edge: assert property (p_invert_edge)
        else $error("invert change did not move output");

    property p_fuse_clear;
        @(posedge clock) disable iff (!resetn)
        (fuse_done_ff && !fuse_ff && !mod_dis_ff) |=> active_ff;
    endproperty
    a_fuse_clear: assert property (p_fuse_clear)
        else $error("fuse clear but detector inactive");

    property p_fuse_set;
        @(posedge clock) disable iff (!resetn)
        (fuse_ff && (!soft_enable_ff || mod_dis_ff)) |=> !active_ff;
    endproperty
    a_fuse_set: assert property (p_fuse_set)
        else $error("detector active without soft enable");

    property p_timer_src;
        @(posedge clock) disable iff (!resetn)
        rise_edge |-> (timer_src.clk_even && timer_src.gate_odd &&
                       timer_src.rst_even && $past(!timer_src.clk_even));
    endproperty
    a_timer_src: assert property (p_timer_src)
        else $error("timer sources disagree with output");

endmodule

// ### testbench/zcl_ac_src.sv
// =====================================================================
// zcl_ac_src: ac waveform behind the series resistor, seen as sink/source
// =====================================================================
// assumes the bench commands which side of the reference the pin sits on
`timescale 1ns/10ps

module zcl_ac_src (
    input  wire logic clock,        // system clock
    input  wire logic level,        // 1 = applied voltage above reference
    input  wire logic slow,         // slow slope: crossing lags eight cycles
    output logic      sink_active   // front end: pin sinking current
);
    logic [7:0] hist_ff;            // delay line of the commanded level
    // above the reference the loop sinks, below it sources
    always_ff @(posedge clock) begin
        hist_ff <= {hist_ff[6:0], level};
    end
    // a slow slope only moves the moment of the crossing, never its sense
    assign sink_active = slow ? hist_ff[7] : hist_ff[0];
endmodule

// ### testbench/zcl_top_tb_top.sv
// =====================================================================
// zcl_top_tb_top: self-checking bench of the zero-cross logic
// =====================================================================
// assumes zcl_pkg, zcl_sync, zcl_top and the ac source model compiled first
`timescale 1ns/10ps

module zcl_top_tb_top;
    import zcl_pkg::*;
    logic           clock, resetn, config_fuse, level, slow, sink_active;
    logic           force_pin_drive, irq;
    logic [7:0]     rdata, got;         // got: last read data
    zcl_bus_req_t   bus_req;            // register request driven here
    zcl_timer_src_t timer_src;          // output offered to timers
    int             fails = 0, samples_checked = 0, cyc = 0;

    zcl_top uut (.clock(clock), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
        .sink_active(sink_active), .config_fuse(config_fuse), .timer_src(timer_src),
        .force_pin_drive(force_pin_drive), .irq(irq));
    zcl_ac_src src (.clock(clock), .level(level), .slow(slow), .sink_active(sink_active));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // the whole run takes about 120 cycles; a hang is cut short here
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic regw(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic regr(input logic [2:0] a);
        @(posedge clock);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1 got = rdata;
    endtask
    task automatic settle(input int n, input logic lv, input logic sl);
        @(posedge clock);
        level <= lv;
        slow <= sl;
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic rst(input logic f);
        @(posedge clock);
        resetn <= 1'b0;
        config_fuse <= f;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
    task automatic t_edges();
        chk("force_pin_drive", 8'h01, {7'h0, force_pin_drive});
        regw(ZCL_OFF_IRQCTL, 8'hc0);
        regw(ZCL_OFF_ENABLES, 8'h01);
        regw(ZCL_OFF_CONTROL, 8'h02);
        settle(12, 1'b1, 1'b0);
        chk("gate_odd", 8'h01, {7'h0, timer_src.gate_odd});
        chk("irq", 8'h01, {7'h0, irq});
        regr(ZCL_OFF_CONTROL);
        chk("control", 8'h22, got);
        regw(ZCL_OFF_FLAGS, 8'h01);
        regr(ZCL_OFF_FLAGS);
        chk("flag cleared", 8'h00, got);
        chk("irq cleared", 8'h00, {7'h0, irq});
        settle(20, 1'b0, 1'b1);
        regr(ZCL_OFF_FLAGS);
        chk("fall not enabled", 8'h00, got);
        $display("t_edges done");
    endtask
    // raw is 0 now, so setting invert makes a rising output edge; the
    // back-to-back flag clear lands in the very cycle that edge sets it
    task automatic t_invert();
        regw(ZCL_OFF_IRQCTL, 8'h40);
        regw(ZCL_OFF_CONTROL, 8'h12);
        regw(ZCL_OFF_FLAGS, 8'h01);
        settle(6, 1'b0, 1'b0);
        chk("clk_even", 8'h01, {7'h0, timer_src.clk_even});
        chk("rst_even", 8'h01, {7'h0, timer_src.rst_even});
        chk("irq gated", 8'h00, {7'h0, irq});
        regr(ZCL_OFF_FLAGS);
        chk("invert edge", 8'h01, got);
        regw(ZCL_OFF_FLAGS, 8'h01);
        regw(ZCL_OFF_CONTROL, 8'h01);
        settle(4, 1'b0, 1'b0);
        regr(ZCL_OFF_FLAGS);
        chk("fall edge", 8'h01, got);
        regr(3'h5);
        chk("unmapped", 8'h00, got);
        $display("t_invert done");
    endtask
    task automatic t_fuse();
        regw(ZCL_OFF_MODDIS, 8'h01);
        settle(4, 1'b0, 1'b0);
        chk("module disable", 8'h00, {7'h0, force_pin_drive});
        rst(1'b1);
        chk("fuse set idle", 8'h00, {7'h0, force_pin_drive});
        regw(ZCL_OFF_CONTROL, 8'h80);
        settle(4, 1'b0, 1'b0);
        chk("soft enable", 8'h01, {7'h0, force_pin_drive});
        $display("t_fuse done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        config_fuse = 1'b0;
        level = 1'b0;
        slow = 1'b0;
        bus_req = '0;
        rst(1'b0);
        t_edges();
        t_invert();
        t_fuse();
        final_report();
    end
endmodule
